// ==== rtl/trce_regs.svh ====
// constants for the transmit rate clock-enable generator
`ifndef TRCE_REGS_SVH
`define TRCE_REGS_SVH
`define TRCE_RATE_W       2
`define TRCE_RATE_10M     2'h0
`define TRCE_RATE_100M    2'h1
`define TRCE_RATE_1G      2'h2
`define TRCE_CNT_W        7
`define TRCE_DIV_100M     7'h0a
`define TRCE_DIV_10M      7'h64
`define TRCE_CNT_ZERO     7'h00
`define TRCE_CNT_ONE      7'h01
`endif

// ==== rtl/trce_pkg.sv ====
// types for the transmit rate clock-enable generator
package trce_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic       dv;
    logic       err;
  } trce_gmii_s;
endpackage

// ==== rtl/trce_div.sv ====
// divider that emits one enable pulse per period
`timescale 1ns/1ps
`default_nettype none
`include "trce_regs.svh"
module trce_div
(
  input  wire logic                    clk_in,
  input  wire logic                    resetn_in,
  input  wire logic                    restart_in,
  input  wire logic [`TRCE_CNT_W-1:0]  period_in,
  output logic                         pulse_out
);
  logic [`TRCE_CNT_W-1:0] cnt_q;
  logic [`TRCE_CNT_W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q + `TRCE_CNT_ONE;
    if (restart_in || cnt_d >= period_in)
      cnt_d = `TRCE_CNT_ZERO;
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      cnt_q <= `TRCE_CNT_ZERO;
    else
      cnt_q <= cnt_d;
  end

  // pulse on count zero, evenly spaced
  assign pulse_out = (cnt_q == `TRCE_CNT_ZERO);
endmodule
`default_nettype wire

// ==== rtl/trce_top.sv ====
// transmit rate clock-enable generator with gated (g)mii capture
// ------------------------------------------------------------
// Summary of operation
// - at gigabit rate the enable output is high every cycle.
// - at 100 Mbps the enable is high one cycle in ten.
// - at 10 Mbps the enable is high one cycle in a hundred.
// - the rate selection inputs choose the enable pattern.
// - the enable is generated in the reference clock domain.
// - transmit data is captured only on edges with enable input high.
// - the reference clock, not a transmit clock, registers transmit data.
// - low reset returns all state, counter included, to initial values.
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "trce_regs.svh"
module trce_top
(
  input  wire logic                    clk_in,
  input  wire logic                    resetn_in,
  input  wire logic [`TRCE_RATE_W-1:0] rate_in,
  input  wire logic                    ce_sink_in,
  input  wire trce_pkg::trce_gmii_s    tx_in,
  output logic                         ce_source_out,
  output trce_pkg::trce_gmii_s         tx_out
);
  // ------------------------------------------------------------
  // rate tracking
  // ------------------------------------------------------------
  logic [`TRCE_RATE_W-1:0] rate_q;
  logic [`TRCE_RATE_W-1:0] rate_d;
  logic                    restart;
  logic [`TRCE_CNT_W-1:0]  period;
  logic                    pulse;

  always_comb
  begin
    rate_d = rate_in;
  end

  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      rate_q <= `TRCE_RATE_1G;
    else
      rate_q <= rate_d;
  end

  // a rate change restarts the count so the new spacing starts clean
  assign restart = (rate_in != rate_q);

  always_comb
  begin
    if (rate_in == `TRCE_RATE_10M)
      period = `TRCE_DIV_10M;
    else if (rate_in == `TRCE_RATE_100M)
      period = `TRCE_DIV_100M;
    else
      period = `TRCE_CNT_ONE;
  end

  // ------------------------------------------------------------
  // enable divider, clocked by the reference clock
  // ------------------------------------------------------------
  trce_div u_div
  (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .restart_in (restart),
    .period_in  (period),
    .pulse_out  (pulse)
  );

  // combinational so the mac sees it in the same cycle as the count
  assign ce_source_out = pulse;

  // ------------------------------------------------------------
  // gated capture of transmit data
  // ------------------------------------------------------------
  trce_pkg::trce_gmii_s cap_q;
  trce_pkg::trce_gmii_s cap_d;

  always_comb
  begin
    cap_d = cap_q;
    if (ce_sink_in)
      cap_d = tx_in;
  end

  // sink input comes from the loop-back of ce_source_out, gated by block in the testbench
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      cap_q <= '0;
    else
      cap_q <= cap_d;
  end

  assign tx_out = cap_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  int unsigned gap_q;
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in || ce_source_out || restart)
      gap_q <= 0;
    else
      gap_q <= gap_q + 1;
  end

  property p_gig_high;
    @(posedge clk_in) disable iff (!resetn_in)
      (rate_in == `TRCE_RATE_1G && !restart) |-> ce_source_out;
  endproperty
  a_gig_high: assert property (p_gig_high)
    else $error("enable low at gigabit rate");

  // a rate change drops pending attempts: the new pattern starts afresh
  sequence s_fast_quiet;
    !ce_source_out [*8] ##1 !ce_source_out ##1 ce_source_out;
  endsequence
  property p_fast_ten;
    @(posedge clk_in) disable iff (!resetn_in || restart)
      (rate_in == `TRCE_RATE_100M && $stable(rate_in) && ce_source_out)
      |=> s_fast_quiet;
  endproperty
  a_fast_ten: assert property (p_fast_ten)
    else $error("100 Mbps enable not one in ten");

  property p_fast_gap;
    @(posedge clk_in) disable iff (!resetn_in)
      (rate_in == `TRCE_RATE_100M && !restart) |-> gap_q < `TRCE_DIV_100M;
  endproperty
  a_fast_gap: assert property (p_fast_gap)
    else $error("100 Mbps enable gap too long");

  // slow period is too long to unroll, so the gap counter carries it
  property p_slow_quiet;
    @(posedge clk_in) disable iff (!resetn_in)
      (rate_in == `TRCE_RATE_10M && !restart && gap_q != 0
       && gap_q < `TRCE_DIV_10M - `TRCE_CNT_ONE) |-> !ce_source_out;
  endproperty
  a_slow_quiet: assert property (p_slow_quiet)
    else $error("extra enable inside 10 Mbps period");

  sequence s_slow_pulse;
    rate_in == `TRCE_RATE_10M && $stable(rate_in) && ce_source_out;
  endsequence
  property p_lone_pulse;
    @(posedge clk_in) disable iff (!resetn_in || restart)
      s_slow_pulse |=> !ce_source_out;
  endproperty
  a_lone_pulse: assert property (p_lone_pulse)
    else $error("10 Mbps enable longer than one cycle");

  property p_slow_gap;
    @(posedge clk_in) disable iff (!resetn_in)
      (rate_in == `TRCE_RATE_10M) |-> gap_q < 100;
  endproperty
  a_slow_gap: assert property (p_slow_gap)
    else $error("10 Mbps enable gap too long");

  property p_slow_spacing;
    @(posedge clk_in) disable iff (!resetn_in)
      (rate_in == `TRCE_RATE_10M && ce_source_out && gap_q != 0
       && $stable(rate_in)) |-> $past(gap_q) == 98;
  endproperty
  a_slow_spacing: assert property (p_slow_spacing)
    else $error("10 Mbps enable spacing wrong");

  property p_restart_pulse;
    @(posedge clk_in) disable iff (!resetn_in)
      restart |=> ce_source_out;
  endproperty
  a_restart_pulse: assert property (p_restart_pulse)
    else $error("rate change did not restart pattern");

  property p_capture;
    @(posedge clk_in) disable iff (!resetn_in)
      ce_sink_in |=> tx_out == $past(tx_in);
  endproperty
  a_capture: assert property (p_capture)
    else $error("data not captured on enabled edge");

  property p_hold;
    @(posedge clk_in) disable iff (!resetn_in)
      !ce_sink_in |=> $stable(tx_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("data changed on disabled edge");

  property p_reset;
    @(posedge clk_in) !resetn_in |=> (tx_out == '0 && ce_source_out);
  endproperty
  a_reset: assert property (p_reset)
    else $error("reset did not clear state");

  property p_reset_rate;
    @(posedge clk_in) !resetn_in |=> rate_q == `TRCE_RATE_1G;
  endproperty
  a_reset_rate: assert property (p_reset_rate)
    else $error("reset did not restore stored rate");

  property p_only_enabled;
    @(posedge clk_in) disable iff (!resetn_in)
      ($changed(tx_out) && $past(resetn_in)) |-> $past(ce_sink_in);
  endproperty
  a_only_enabled: assert property (p_only_enabled)
    else $error("captured data moved without enable");

  // no rate ever lets the counter run past the slowest period
  property p_gap_bound;
    @(posedge clk_in) disable iff (!resetn_in)
      gap_q < `TRCE_DIV_10M;
  endproperty
  a_gap_bound: assert property (p_gap_bound)
    else $error("enable gap beyond slowest period");

  property p_gig_next;
    @(posedge clk_in) disable iff (!resetn_in)
      (rate_in == `TRCE_RATE_1G && !restart) |=> ce_source_out;
  endproperty
  a_gig_next: assert property (p_gig_next)
    else $error("enable dropped after gigabit cycle");
endmodule
`default_nettype wire

// ==== tb/trce_mac.sv ====
// mac transmit model for the rate clock-enable generator
`timescale 1ns/1ps
`default_nettype none
module trce_mac
(
  input  wire logic            clk_in,
  input  wire logic            resetn_in,
  input  wire logic            ce_in,
  output trce_pkg::trce_gmii_s tx_out
);
  // ----
  // octet source
  // ----
  // new octet only on enabled reference edges
  always_ff @(posedge clk_in)
  begin
    if (!resetn_in)
      tx_out <= '0;
    else if (ce_in)
      tx_out <= '{data: tx_out.data + 8'h01, dv: 1'b1, err: tx_out.data[0]};
  end
endmodule
`default_nettype wire

// ==== tb/trce_top_tb.sv ====
// testbench for the transmit rate clock-enable generator
`timescale 1ns/1ps
`default_nettype none
`include "trce_regs.svh"
module trce_top_tb;
  logic                    clk_in = 1'b0;
  logic                    resetn_in = 1'b0;
  logic [`TRCE_RATE_W-1:0] rate_in = `TRCE_RATE_1G;
  logic                    block = 1'b0;
  logic                    ce_src;
  logic                    ce_snk;
  trce_pkg::trce_gmii_s    mac_tx;
  trce_pkg::trce_gmii_s    cap;
  trce_pkg::trce_gmii_s    exp_q = '0;
  int                      n_fail = 0;
  int                      comparisons = 0;
  // ----
  // clock, loopback, models
  // ----
  always #50 clk_in = ~clk_in;
  // block breaks the loop so gating is visible
  assign ce_snk = ce_src & ~block;
  // expected capture: taken on enabled edges only
  always @(posedge clk_in)
    if (!resetn_in) exp_q <= '0;
    else if (ce_snk) exp_q <= mac_tx;
  trce_mac mac_u (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_src),
                  .tx_out(mac_tx));
  trce_top dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .rate_in(rate_in),
                  .ce_sink_in(ce_snk), .tx_in(mac_tx),
                  .ce_source_out(ce_src), .tx_out(cap));
  // ----
  // tasks
  // ----
  task step();
    @(posedge clk_in);
    #1;
  endtask
  task cmp_v(input logic [9:0] got, input logic [9:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test();
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // window of 200 cycles holds whole periods at every rate
  task t_rate(input logic [1:0] r, input logic [9:0] n);
    logic [9:0] cnt;
    cnt = '0;
    rate_in = r;
    repeat (3) step();
    repeat (200)
    begin
      step();
      cnt = cnt + {9'h000, ce_src};
      cmp_v(cap, exp_q);
    end
    cmp_v(cnt, n);
  endtask
  task t_restart();
    rate_in = `TRCE_RATE_10M;
    repeat (37) step();
    rate_in = `TRCE_RATE_100M;
    step();
    cmp_v({9'h000, ce_src}, 10'h001);
  endtask
  task t_gate();
    trce_pkg::trce_gmii_s held;
    rate_in = `TRCE_RATE_1G;
    repeat (3) step();
    block = 1'b1;
    held = cap;
    repeat (5) step();
    cmp_v(cap, held);
    block = 1'b0;
    repeat (2) step();
    cmp_v(cap, exp_q);
  endtask
  task t_reset();
    resetn_in = 1'b0;
    step();
    cmp_v(cap, 10'h000);
    cmp_v({9'h000, ce_src}, 10'h001);
    resetn_in = 1'b1;
  endtask
  // ----
  // sequence and watchdog
  // ----
  initial
  begin
    #400000;
    n_fail++;
    end_of_test();
  end
  initial
  begin
    repeat (10) @(posedge clk_in);
    #1;
    resetn_in = 1'b1;
    t_rate(`TRCE_RATE_1G, 10'h0c8);
    t_rate(`TRCE_RATE_100M, 10'h014);
    t_rate(`TRCE_RATE_10M, 10'h002);
    t_rate(2'h3, 10'h0c8);
    t_restart();
    t_gate();
    t_rate(`TRCE_RATE_100M, 10'h014);
    t_reset();
    t_rate(`TRCE_RATE_10M, 10'h002);
    end_of_test();
  end
endmodule
`default_nettype wire
